// File: dv/pst_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
// Bus controller model; the clock stands high between frames, 80 ns a bit.
module pst_ctrl_model (
  // Pacing clock and wire level.
  input  wire logic core_clk,
  input  wire logic sda,
  // Controller pins; sda_low pulls the data line down.
  output var  logic scl,
  output var  logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Start or restart: data falls while clock high.
  task automatic start();
    q(2);
    sda_low = 1'b0;
    q(3);
    scl = 1'b1;
    q(3);
    sda_low = 1'b1;
    q(3);
    scl = 1'b0;
  endtask
  // One bit: data moves only while clock is low; sampled late in the high phase.
  task automatic bit_io(input logic b, output logic s);
    q(2);
    sda_low = !b;
    q(3);
    scl = 1'b1;
    q(3);
    s = sda;
    q(2);
    scl = 1'b0;
  endtask
  // Byte then acknowledge slot; rel releases the line in that slot.
  task automatic xfer(input logic [7:0] w, input logic rel, output logic [7:0] r,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(rel, s);
    ack = !s;
  endtask
  // Stop: data rises while clock high, then the bus stands idle.
  task automatic stop();
    q(2);
    sda_low = 1'b1;
    q(3);
    scl = 1'b1;
    q(3);
    sda_low = 1'b0;
    q(6);
  endtask
endmodule // pst_ctrl_model
`default_nettype wire

// File: dv/pst_i2c_target_props.sv
`timescale 1ns/1ns
`default_nettype none
// Port checker for the target; it sees only the top module's ports.
module pst_i2c_target_props (
  // Watched ports.
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       meas_start,
  input wire logic       meas_done,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic       busy,
  input wire logic       addressed
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  reset_quiet_a: assert property ($fell(rst) |-> !sda_oe && !busy && !addressed)
    else $error("Outputs not idle after reset.");
  open_drain_a: assert property (!sda_o)
    else $error("Data pin driven high.");
  start_pulse_a: assert property (meas_start |=> !meas_start)
    else $error("Measurement start longer than one cycle.");
  busy_set_a: assert property (meas_start |-> busy)
    else $error("Busy not set by measurement start.");
  busy_ignore_a: assert property (busy && !meas_done |=> !meas_start)
    else $error("Command started while busy.");
  busy_hold_a: assert property (busy && !meas_done |=> busy)
    else $error("Busy dropped without completion.");
  busy_clear_a: assert property (busy && meas_done |=> !busy)
    else $error("Busy not cleared by completion.");
  // A change of the drive must follow a clock fall, never a long high phase.
  oe_stands_a: assert property (scl_i [*5] |=> $stable(sda_oe))
    else $error("Data drive changed while clock high.");
  rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("Stalled byte not held.");
  // Main scenarios reached.
  cov_start: cover property (meas_start);
  cov_done: cover property (busy && meas_done);
  cov_stall: cover property (rx_valid && !rx_ready);
endmodule // pst_i2c_target_props
bind pst_i2c_target pst_i2c_target_props pst_i2c_target_props_inst (.core_clk(core_clk),
  .rst(rst), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .meas_start(meas_start),
  .meas_done(meas_done), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
  .busy(busy), .addressed(addressed));
`default_nettype wire

// File: dv/pst_i2c_target_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pst_i2c_target_tb;
  logic        core_clk, rst, meas_done, stat_mode, stat_crc_err, rx_ready;
  logic        scl, sda_low, sda_o, sda_oe, meas_start, rx_valid, busy, addressed;
  logic [7:0]  rx_data;
  logic [7:0]  rxq[$];
  int          n_mismatch, num_checks, n_start;
  // Open-drain wire with pull-up.
  wire logic   sda = !(sda_low | sda_oe);
  pst_ctrl_model ctl_inst (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  pst_i2c_target pst_i2c_target_inst (.core_clk(core_clk), .rst(rst), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .meas_start(meas_start),
    .meas_done(meas_done), .meas_press(24'hE63294), .meas_temp(16'h5763),
    .stat_mode(stat_mode), .stat_crc_err(stat_crc_err), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .busy(busy), .addressed(addressed));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = !core_clk;
  end
  // Count starts and collect streamed bytes.
  always @(posedge core_clk) begin
    if (meas_start === 1'b1) n_start++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Opening byte to own address, direction write.
  task automatic open_wr();
    logic [7:0] r;
    logic a;
    ctl_inst.start();
    ctl_inst.xfer(8'hF0, 1'b1, r, a);
    chk(a, 1'b1);
    chk(addressed, 1'b1);
  endtask
  task automatic t_naddr();
    logic [7:0] r;
    logic a;
    ctl_inst.start();
    ctl_inst.xfer(8'hF2, 1'b1, r, a);
    chk(a, 1'b0);
    chk(addressed, 1'b0);
    ctl_inst.stop();
    $display("t_naddr done");
  endtask
  // Command write; a repeat while busy must not start again.
  task automatic t_cmd();
    logic [7:0] r;
    logic a;
    for (int k = 0; k < 2; k++) begin
      open_wr();
      ctl_inst.xfer(8'hAC, 1'b1, r, a);
      chk(a, 1'b1);
      ctl_inst.stop();
      chk(addressed, 1'b0);
      chk(n_start, 1);
      chk(busy, 1'b1);
    end
    $display("t_cmd done");
  endtask
  // Read n bytes, optionally after a write address and restart.
  task automatic t_rd(input logic rs, input logic [47:0] ex, input int n);
    logic [7:0] r;
    logic a;
    if (rs) open_wr();
    ctl_inst.start();
    ctl_inst.xfer(8'hF1, 1'b1, r, a);
    chk(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      ctl_inst.xfer(8'hFF, i == n - 1, r, a);
      chk(r, ex[47-8*i -: 8]);
    end
    chk(a, 1'b0);
    ctl_inst.stop();
    $display("t_rd done");
  endtask
  // Fill the buffer while stalled, then drain and compare.
  task automatic t_fifo();
    logic [7:0] r;
    logic a;
    rx_ready = 1'b0;
    rxq.delete();
    open_wr();
    // Eight buffered words plus the two output registers hold ten bytes.
    for (int i = 0; i < 11; i++) begin
      ctl_inst.xfer(8'h30 + i[7:0], 1'b1, r, a);
      chk(a, i < 10);
    end
    ctl_inst.stop();
    rx_ready = 1'b1;
    for (int k = 0; k < 100 && rxq.size() < 10; k++) @(negedge core_clk);
    chk(rxq.size(), 10);
    for (int i = 0; i < 10 && i < rxq.size(); i++) chk(rxq[i], 8'h30 + i[7:0]);
    $display("t_fifo done");
  endtask
  initial begin
    #400000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    meas_done = 1'b0;
    stat_mode = 1'b1;
    stat_crc_err = 1'b0;
    rx_ready = 1'b1;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    t_naddr();
    t_cmd();
    t_rd(1'b1, {8'h68, 40'h0}, 1);
    meas_done = 1'b1;
    @(negedge core_clk);
    meas_done = 1'b0;
    stat_mode = 1'b0;
    stat_crc_err = 1'b1;
    @(negedge core_clk);
    chk(busy, 1'b0);
    t_rd(1'b0, 48'h44E632945763, 6);
    t_fifo();
    wrap_up();
  end
endmodule // pst_i2c_target_tb
`default_nettype wire

// File: hw/pst_defs.vh
`ifndef PST_DEFS_VH
`define PST_DEFS_VH
`define PST_ADDR_DEFAULT   7'h78
`define PST_CMD_MEASURE    8'hAC
`define PST_RESP_BYTES     3'd6
`define PST_STAT_POWER_BIT 6
`define PST_STAT_BUSY_BIT  5
`define PST_STAT_MODE_BIT  3
`define PST_STAT_CRC_BIT   2
`define PST_FIFO_WIDTH     8
`define PST_FIFO_DEPTH     8
`endif

// File: hw/pst_fifo.v
`timescale 1ns/1ns
`default_nettype none
module pst_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset.
  input  wire             core_clk,
  input  wire             rst,
  // Fill side.
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side.
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wp_q;
  reg [AW:0]      rp_q;
  reg             ov_q;
  wire            empty = (wp_q == rp_q);
  wire            full  = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  wire            pop   = !empty && (!ov_q || out_ready);

  assign in_ready  = !full;
  assign out_valid = ov_q;

  // Read data come out of a register so the drain side sees a flopped word.
  always @(posedge core_clk) begin
    if (rst) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
      ov_q <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (in_valid && !full) begin
        mem[wp_q[AW-1:0]] <= in_data;
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        out_data <= mem[rp_q[AW-1:0]];
        rp_q <= rp_q + 1'b1;
        ov_q <= 1'b1;
      end else if (out_ready) begin
        ov_q <= 1'b0;
      end
    end
  end
endmodule // pst_fifo
`default_nettype wire

// File: hw/pst_i2c_target.v
// Function
// - Bytes shift most significant bit first.
// - Answer only own seven-bit address, acknowledge.
// - Start is data falling while clock high.
// - Repeated start restarts addressing.
// - Eighth address bit selects direction.
// - Acknowledge each received byte when addressed and the FIFO has room.
// - Sender releases data during acknowledge.
// - No acknowledge when unaddressed or unable.
// - Read response starts with status byte.
// - Command 0xAC starts one measurement.
// - Commands ignored while busy.
// - Read returns status, pressure three, temperature two.
`timescale 1ns/1ns
`default_nettype none
`include "pst_defs.vh"
module pst_i2c_target #(
  parameter [6:0] BUS_ADDR = `PST_ADDR_DEFAULT
) (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        rst,
  // Serial pins, open drain.
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe,
  // Sensor core side.
  output reg         meas_start,
  input  wire        meas_done,
  input  wire [23:0] meas_press,
  input  wire [15:0] meas_temp,
  input  wire        stat_mode,
  input  wire        stat_crc_err,
  // Received data bytes stream.
  output reg         rx_valid,
  input  wire        rx_ready,
  output reg  [7:0]  rx_data,
  // Measurement and transfer status.
  output reg         busy,
  output reg         addressed
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_AACK = 3'd2;
  localparam ST_WR   = 3'd3;
  localparam ST_WACK = 3'd4;
  localparam ST_RD   = 3'd5;
  localparam ST_RACK = 3'd6;

  // Three-stage synchronisers; stage one feeds stage two only.
  reg  [2:0] scl_s_q;
  reg  [2:0] sda_s_q;
  reg        scl_q;
  reg        sda_q;
  always @(posedge core_clk) begin
    if (rst) begin
      scl_s_q <= 3'b111;
      sda_s_q <= 3'b111;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
      if (scl_s_q[1] == scl_s_q[2])
        scl_q <= scl_s_q[2];
      if (sda_s_q[1] == sda_s_q[2])
        sda_q <= sda_s_q[2];
    end
  end

  reg scl_d1_q;
  reg sda_d1_q;
  always @(posedge core_clk) begin
    if (rst) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_d1_q <= scl_q;
      sda_d1_q <= sda_q;
    end
  end
  wire scl_rise = scl_q && !scl_d1_q;
  wire scl_fall = !scl_q && scl_d1_q;
  wire start_c  = scl_q && scl_d1_q && sda_d1_q && !sda_q;
  wire stop_c   = scl_q && scl_d1_q && !sda_d1_q && sda_q;

  // Received bytes pass through the FIFO to the stream port and command decode.
  reg        fin_valid_q;
  reg  [7:0] fin_data_q;
  wire       fin_ready;
  wire       fout_valid;
  wire [7:0] fout_data;
  wire       fout_ready = !rx_valid || rx_ready;
  pst_fifo #(
    .WIDTH(`PST_FIFO_WIDTH),
    .DEPTH(`PST_FIFO_DEPTH),
    .AW   (3)
  ) u_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .in_valid (fin_valid_q),
    .in_ready (fin_ready),
    .in_data  (fin_data_q),
    .out_valid(fout_valid),
    .out_ready(fout_ready),
    .out_data (fout_data)
  );

  // Stream output register and command decode on bytes leaving the FIFO.
  reg        first_q;
  reg        cmd_flag_q;
  reg        meas_pend_q;
  always @(posedge core_clk) begin
    if (rst) begin
      rx_valid   <= 1'b0;
      rx_data    <= 8'h00;
      meas_start <= 1'b0;
      busy       <= 1'b0;
    end else begin
      meas_start <= 1'b0;
      if (fout_ready) begin
        rx_valid <= fout_valid;
        if (fout_valid)
          rx_data <= fout_data;
      end
      if (fout_valid && fout_ready && !busy && fout_data == `PST_CMD_MEASURE) begin
        meas_start <= 1'b1;
        busy       <= 1'b1;
      end else if (meas_done) begin
        busy <= 1'b0;
      end
    end
  end

  // Status byte and response shift data.
  reg  [7:0] status_byte;
  always @* begin
    status_byte = 8'h00;
    status_byte[`PST_STAT_POWER_BIT] = 1'b1;
    status_byte[`PST_STAT_BUSY_BIT]  = busy;
    status_byte[`PST_STAT_MODE_BIT]  = stat_mode;
    status_byte[`PST_STAT_CRC_BIT]   = stat_crc_err;
  end
  reg  [2:0] byte_idx_q;
  reg  [7:0] tx_byte;
  wire [2:0] nxt_idx = byte_idx_q + 3'd1;
  always @* begin
    case (nxt_idx)
      3'd0:    tx_byte = status_byte;
      3'd1:    tx_byte = meas_press[23:16];
      3'd2:    tx_byte = meas_press[15:8];
      3'd3:    tx_byte = meas_press[7:0];
      3'd4:    tx_byte = meas_temp[15:8];
      3'd5:    tx_byte = meas_temp[7:0];
      default: tx_byte = 8'hFF;
    endcase
  end

  reg [2:0] st_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg       rw_q;
  reg       ack_ok_q;
  reg       got8_q;
  // Port state machine; a start or stop overrides everything.
  always @(posedge core_clk) begin
    if (rst) begin
      st_q        <= ST_IDLE;
      bit_q       <= 3'd0;
      sh_q        <= 8'h00;
      rw_q        <= 1'b0;
      ack_ok_q    <= 1'b0;
      got8_q      <= 1'b0;
      byte_idx_q  <= 3'd0;
      sda_o       <= 1'b0;
      sda_oe      <= 1'b0;
      addressed   <= 1'b0;
      fin_valid_q <= 1'b0;
      fin_data_q  <= 8'h00;
    end else begin
      fin_valid_q <= 1'b0;
      if (start_c) begin
        st_q      <= ST_ADDR;
        bit_q     <= 3'd0;
        got8_q    <= 1'b0;
        sda_oe    <= 1'b0;
        addressed <= 1'b0;
      end else if (stop_c) begin
        st_q      <= ST_IDLE;
        sda_oe    <= 1'b0;
        addressed <= 1'b0;
      end else begin
        case (st_q)
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_q};
              bit_q <= bit_q + 3'd1;
              if (bit_q == 3'd7)
                got8_q <= 1'b1;
            end
            // Act only after eight rises, never on the fall that closes a start.
            if (scl_fall && got8_q) begin
              got8_q <= 1'b0;
              if (st_q == ST_ADDR) begin
                rw_q     <= sh_q[0];
                ack_ok_q <= (sh_q[7:1] == BUS_ADDR);
                sda_oe   <= (sh_q[7:1] == BUS_ADDR);
                st_q     <= ST_AACK;
                addressed <= (sh_q[7:1] == BUS_ADDR);
              end else begin
                ack_ok_q    <= fin_ready;
                sda_oe      <= fin_ready;
                fin_valid_q <= fin_ready;
                fin_data_q  <= sh_q;
                st_q        <= ST_WACK;
              end
            end
          end
          ST_AACK, ST_WACK: begin
            if (scl_fall) begin
              if (!ack_ok_q) begin
                sda_oe <= 1'b0;
                st_q   <= ST_IDLE;
              end else if (st_q == ST_AACK && rw_q) begin
                byte_idx_q <= 3'd0;
                sh_q       <= status_byte;
                sda_oe     <= !status_byte[7];
                bit_q      <= 3'd0;
                st_q       <= ST_RD;
              end else begin
                sda_oe <= 1'b0;
                bit_q  <= 3'd0;
                st_q   <= ST_WR;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bit_q == 3'd7) begin
                sda_oe <= 1'b0;
                st_q   <= ST_RACK;
              end else begin
                sh_q   <= {sh_q[6:0], 1'b0};
                sda_oe <= !sh_q[6];
              end
              bit_q <= bit_q + 3'd1;
            end
          end
          ST_RACK: begin
            if (scl_rise)
              ack_ok_q <= !sda_q;
            if (scl_fall) begin
              if (!ack_ok_q) begin
                st_q <= ST_IDLE;
              end else begin
                // Past the last byte the index stays put and the mux yields all ones.
                if (byte_idx_q < `PST_RESP_BYTES - 3'd1)
                  byte_idx_q <= nxt_idx;
                sh_q   <= tx_byte;
                sda_oe <= !tx_byte[7];
                bit_q <= 3'd0;
                st_q  <= ST_RD;
              end
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // pst_i2c_target
`default_nettype wire
